/* logic/ealu_map.svh */
// Offsets, field positions, reset values and cycle counts of the arithmetic unit
`ifndef EALU_MAP_SVH
`define EALU_MAP_SVH

// Bus geometry
`define EALU_ADDR_W 8
`define EALU_DATA_W 32

// Register byte offsets
`define EALU_OFF_CTRL 8'h00
`define EALU_OFF_OPA 8'h04
`define EALU_OFF_OPB 8'h08
`define EALU_OFF_FLAGS 8'h0C
`define EALU_OFF_PROD 8'h10
`define EALU_OFF_STAT 8'h14

// Field positions
`define EALU_CTRL_GO 8
`define EALU_STAT_BUSY 0
`define EALU_STAT_DONE 1
`define EALU_FLG_C 0
`define EALU_FLG_Z 1
`define EALU_FLG_N 2
`define EALU_FLG_V 3
`define EALU_FLG_S 4
`define EALU_FLG_H 5

// Number of defined operation codes
`define EALU_OP_COUNT 5'h17

// Reset values
`define EALU_RST_FLAGS 6'h00
`define EALU_RST_OPND 16'h0000

// Constants of the datapath
`define EALU_BYTE_ONES 8'hFF
`define EALU_MIN_NEG 8'h80
`define EALU_MAX_POS 8'h7F

// Remaining execute cycles after the first one
`define EALU_CYC_ONE 1'b0
`define EALU_CYC_TWO 1'b1

`endif

/* logic/ealu_pkg.sv */
// Types shared by the 8-bit arithmetic and logic unit
`include "ealu_map.svh"

package ealu_pkg;

    // Operation codes, numbered 0 upward in this order
    typedef enum logic [4:0] {
        sum_two_regs, sum_with_carry_in, word_immediate_plus, difference_regs,
        difference_const, difference_with_borrow, difference_const_borrow,
        word_immediate_minus, bitwise_conj_regs, bitwise_conj_const,
        bitwise_disj_regs, bitwise_disj_const, bitwise_xor_regs, bit_set_mask,
        bit_clear_mask, plus_one, minus_one, zero_sign_check, zero_fill,
        unsigned_product, signed_product, bit_invert, arith_inverse
    } ealu_op_e;

    typedef enum logic {st_idle, st_exec} ealu_state_e;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [`EALU_ADDR_W-1:0] paddr;
        logic [`EALU_DATA_W-1:0] pwdata;
    } ealu_apb_req_s;

    typedef struct packed {
        logic [`EALU_DATA_W-1:0] prdata;
        logic pready;
        logic pslverr;
    } ealu_apb_rsp_s;

    typedef struct packed {
        ealu_state_e st;
        ealu_op_e op;
        logic [15:0] opa;
        logic [7:0] opb;
        logic [5:0] flags;
        logic [15:0] prod;
        logic cnt;
        logic busy;
        logic done;
        ealu_apb_rsp_s rsp;
    } ealu_state_s;

endpackage

/* logic/ealu_core.sv */
// Arithmetic and logic unit of an 8-bit core with an APB register port
`timescale 1ns/100ps
`include "ealu_map.svh"

// Contract
// - sum_two_regs adds src_reg to dest_reg; carry variant adds C; ZCNVH; one cycle
// - word_immediate_plus adds imm to register pair; ZCNVS flags; two cycles
// - difference_regs/const subtract operand from dest_reg; ZCNVH; one cycle
// - Borrow variants subtract operand and carry; ZCNVH; one cycle
// - word_immediate_minus subtracts imm from register pair; ZCNVS; two cycles
// - AND of dest_reg with operand; only Z, N, V change; one cycle
// - OR or XOR of dest_reg with operand; Z, N, V; one cycle
// - bit_set_mask sets bits that are one in imm; Z, N, V; one cycle
// - bit_clear_mask ANDs dest_reg with 0xFF minus imm; Z, N, V; one cycle
// - plus_one and minus_one change Z, N, V only, carry kept; one cycle
// - zero_sign_check ANDs dest_reg with itself; zero_fill XORs to zero; one cycle
// - unsigned_product multiplies unsigned into product_pair; only Z and C change
// - signed_product multiplies signed into product_pair in two cycles; Z and C
module ealu_core (
    input wire logic pclk,
    input wire logic presetn,
    input wire ealu_pkg::ealu_apb_req_s apb_req,
    output ealu_pkg::ealu_apb_rsp_s apb_rsp,
    output logic alu_busy
);
    import ealu_pkg::*;

    ealu_state_s q;
    ealu_state_s n;

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Half carry and overflow of an 8-bit addition, as {h, v}
    function automatic logic [1:0] add_hv(input logic [7:0] x, input logic [7:0] y,
                                          input logic [7:0] r);
        add_hv = {(x[3] & y[3]) | (y[3] & ~r[3]) | (~r[3] & x[3]),
                  (x[7] & y[7] & ~r[7]) | (~x[7] & ~y[7] & r[7])};
    endfunction

    // Half borrow and overflow of an 8-bit subtraction, as {h, v}
    function automatic logic [1:0] sub_hv(input logic [7:0] x, input logic [7:0] y,
                                          input logic [7:0] r);
        sub_hv = {(~x[3] & y[3]) | (y[3] & r[3]) | (r[3] & ~x[3]),
                  (x[7] & ~y[7] & ~r[7]) | (~x[7] & y[7] & r[7])};
    endfunction

    // Operations that need a second execute cycle
    function automatic logic op_long(input ealu_op_e o);
        op_long = (o == word_immediate_plus) || (o == word_immediate_minus) ||
                  (o == unsigned_product) || (o == signed_product);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode

    logic commit;
    logic op_ok;
    logic go;
    ealu_op_e new_op;

    // A write lands only at the edge where the master sees pready without error
    assign commit = apb_req.psel & apb_req.penable & q.rsp.pready & apb_req.pwrite &
                    ~q.rsp.pslverr;
    assign op_ok = apb_req.pwdata[4:0] < `EALU_OP_COUNT;
    assign new_op = ealu_op_e'(apb_req.pwdata[4:0]);
    assign go = commit & (apb_req.paddr == `EALU_OFF_CTRL) & apb_req.pwdata[`EALU_CTRL_GO] &
                ~q.busy & op_ok;

    ////////////////////////////////////////////////////////////////////////////////
    // Datapath

    logic [7:0] res8;
    logic [15:0] res16;
    logic [15:0] prod16;
    logic [5:0] flg;
    logic wr8;
    logic wr16;
    logic wrp;

    // Result and flags of the held operation from the held operands
    always_comb begin
        logic [8:0] s9;
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] x;
        logic [7:0] y;
        logic c;
        logic keep_z;
        a = q.opa[7:0];
        b = q.opb;
        x = 8'h00;
        y = 8'h00;
        c = q.flags[`EALU_FLG_C];
        s9 = 9'h000;
        keep_z = 1'b0;
        res8 = a;
        res16 = q.opa;
        prod16 = q.prod;
        flg = q.flags;
        wr8 = 1'b1;
        wr16 = 1'b0;
        wrp = 1'b0;
        case (q.op)
            sum_two_regs, sum_with_carry_in: begin
                s9 = {1'b0, a} + {1'b0, b} + {8'h00, (q.op == sum_with_carry_in) & c};
                res8 = s9[7:0];
                flg[`EALU_FLG_C] = s9[8];
                {flg[`EALU_FLG_H], flg[`EALU_FLG_V]} = add_hv(a, b, res8);
            end
            difference_regs, difference_const, difference_with_borrow,
            difference_const_borrow, arith_inverse: begin
                x = (q.op == arith_inverse) ? 8'h00 : a;
                y = (q.op == arith_inverse) ? a : b;
                keep_z = (q.op == difference_with_borrow) || (q.op == difference_const_borrow);
                s9 = {1'b0, x} - {1'b0, y} - {8'h00, keep_z & c};
                res8 = s9[7:0];
                flg[`EALU_FLG_C] = s9[8];
                {flg[`EALU_FLG_H], flg[`EALU_FLG_V]} = sub_hv(x, y, res8);
            end
            word_immediate_plus: begin
                res16 = q.opa + {8'h00, b};
                flg[`EALU_FLG_V] = ~q.opa[15] & res16[15];
                flg[`EALU_FLG_C] = q.opa[15] & ~res16[15];
            end
            word_immediate_minus: begin
                res16 = q.opa - {8'h00, b};
                flg[`EALU_FLG_V] = q.opa[15] & ~res16[15];
                flg[`EALU_FLG_C] = ~q.opa[15] & res16[15];
            end
            bitwise_conj_regs, bitwise_conj_const, zero_sign_check: begin
                res8 = (q.op == zero_sign_check) ? (a & a) : (a & b);
                flg[`EALU_FLG_V] = 1'b0;
            end
            bitwise_disj_regs, bitwise_disj_const, bit_set_mask: begin
                res8 = a | b;
                flg[`EALU_FLG_V] = 1'b0;
            end
            bitwise_xor_regs, zero_fill: begin
                res8 = (q.op == zero_fill) ? (a ^ a) : (a ^ b);
                flg[`EALU_FLG_V] = 1'b0;
            end
            bit_clear_mask: begin
                res8 = a & (`EALU_BYTE_ONES - b);
                flg[`EALU_FLG_V] = 1'b0;
            end
            plus_one: begin
                res8 = 8'(a + 8'h01);
                flg[`EALU_FLG_V] = res8 == `EALU_MIN_NEG;
            end
            minus_one: begin
                res8 = 8'(a - 8'h01);
                flg[`EALU_FLG_V] = res8 == `EALU_MAX_POS;
            end
            bit_invert: begin
                res8 = `EALU_BYTE_ONES - a;
                flg[`EALU_FLG_C] = 1'b1;
                flg[`EALU_FLG_V] = 1'b0;
            end
            unsigned_product: begin
                prod16 = {8'h00, a} * {8'h00, b};
            end
            signed_product: begin
                prod16 = 16'($signed({{8{a[7]}}, a}) * $signed({{8{b[7]}}, b}));
            end
            default: begin
                wr8 = 1'b0;
            end
        endcase
        // Word and product results replace the byte write-back
        if (q.op == word_immediate_plus || q.op == word_immediate_minus) begin
            wr8 = 1'b0;
            wr16 = 1'b1;
            flg[`EALU_FLG_N] = res16[15];
            flg[`EALU_FLG_Z] = res16 == 16'h0000;
            flg[`EALU_FLG_S] = res16[15] ^ flg[`EALU_FLG_V];
        end else if (q.op == unsigned_product || q.op == signed_product) begin
            wr8 = 1'b0;
            wrp = 1'b1;
            flg[`EALU_FLG_C] = prod16[15];
            flg[`EALU_FLG_Z] = prod16 == 16'h0000;
        end else if (wr8) begin
            flg[`EALU_FLG_N] = res8[7];
            flg[`EALU_FLG_Z] = (res8 == 8'h00) & (~keep_z | q.flags[`EALU_FLG_Z]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    // Bus answer, register writes, start and completion of an operation
    always_comb begin
        n = q;
        n.rsp.pready = apb_req.psel & apb_req.penable & ~q.rsp.pready;
        n.rsp.pslverr = 1'b0;
        n.rsp.prdata = '0;
        if (n.rsp.pready) begin
            case (apb_req.paddr)
                `EALU_OFF_CTRL: begin
                    n.rsp.prdata[4:0] = q.op;
                    n.rsp.pslverr = apb_req.pwrite & (q.busy | ~op_ok);
                end
                `EALU_OFF_OPA: begin
                    n.rsp.prdata[15:0] = q.opa;
                    n.rsp.pslverr = apb_req.pwrite & q.busy;
                end
                `EALU_OFF_OPB: begin
                    n.rsp.prdata[7:0] = q.opb;
                    n.rsp.pslverr = apb_req.pwrite & q.busy;
                end
                `EALU_OFF_FLAGS: begin
                    n.rsp.prdata[5:0] = q.flags;
                    n.rsp.pslverr = apb_req.pwrite & q.busy;
                end
                `EALU_OFF_PROD: begin
                    n.rsp.prdata[15:0] = q.prod;
                end
                `EALU_OFF_STAT: begin
                    n.rsp.prdata[`EALU_STAT_BUSY] = q.busy;
                    n.rsp.prdata[`EALU_STAT_DONE] = q.done;
                end
                default: begin
                    n.rsp.pslverr = 1'b1;
                end
            endcase
        end
        // Register writes; busy refusals never reach here
        if (commit) begin
            case (apb_req.paddr)
                `EALU_OFF_CTRL: n.op = new_op;
                `EALU_OFF_OPA: n.opa = apb_req.pwdata[15:0];
                `EALU_OFF_OPB: n.opb = apb_req.pwdata[7:0];
                `EALU_OFF_FLAGS: n.flags = apb_req.pwdata[5:0];
                default: n.op = q.op;
            endcase
        end
        // Start of an operation
        if (go) begin
            n.st = st_exec;
            n.busy = 1'b1;
            n.done = 1'b0;
            n.cnt = op_long(new_op) ? `EALU_CYC_TWO : `EALU_CYC_ONE;
        end
        // Execute cycles and write-back
        case (q.st)
            st_idle: begin
                n.cnt = go ? n.cnt : `EALU_CYC_ONE;
            end
            st_exec: begin
                if (q.cnt) begin
                    n.cnt = `EALU_CYC_ONE;
                end else begin
                    n.st = st_idle;
                    n.busy = 1'b0;
                    n.done = 1'b1;
                    n.flags = flg;
                    if (wr8) begin
                        n.opa[7:0] = res8;
                    end
                    if (wr16) begin
                        n.opa = res16;
                    end
                    if (wrp) begin
                        n.prod = prod16;
                    end
                end
            end
            default: begin
                n.st = st_idle;
            end
        endcase
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign apb_rsp = q.rsp;
    assign alu_busy = q.busy;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    logic [15:0] umul_ref;
    logic [15:0] smul_ref;

    // Reference products from the held operands
    assign umul_ref = {8'h00, q.opa[7:0]} * {8'h00, q.opb};
    assign smul_ref = 16'($signed({{8{q.opa[7]}}, q.opa[7:0]}) * $signed({{8{q.opb[7]}}, q.opb}));

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_go(ealu_op_e o);
        go && new_op == o;
    endsequence

    sequence s_one_cycle;
        q.busy ##1 (!q.busy && q.done);
    endsequence

    sequence s_two_cycles;
        q.busy [*2] ##1 (!q.busy && q.done);
    endsequence

    a_add_result: assert property (s_go(sum_two_regs) |=> s_one_cycle ##0
        q.opa[7:0] == 8'($past(q.opa[7:0], 2) + $past(q.opb, 2)))
        else $error("sum of two registers wrong or late");
    a_adc_carry: assert property (s_go(sum_with_carry_in) |=> ##1
        q.opa[7:0] == 8'($past(q.opa[7:0], 2) + $past(q.opb, 2) +
                        {7'h00, $past(q.flags[`EALU_FLG_C], 2)}))
        else $error("sum with carry wrong");
    a_word_plus_time: assert property (s_go(word_immediate_plus) |=> s_two_cycles ##0
        q.opa == 16'($past(q.opa, 3) + {8'h00, $past(q.opb, 3)}))
        else $error("word add wrong or not two cycles");
    a_sub_result: assert property (s_go(difference_regs) |=> s_one_cycle ##0
        q.opa[7:0] == 8'($past(q.opa[7:0], 2) - $past(q.opb, 2)))
        else $error("difference wrong or late");
    a_sbc_borrow: assert property (s_go(difference_with_borrow) |=> ##1
        q.opa[7:0] == 8'($past(q.opa[7:0], 2) - $past(q.opb, 2) -
                        {7'h00, $past(q.flags[`EALU_FLG_C], 2)}))
        else $error("difference with borrow wrong");
    a_word_minus_time: assert property (s_go(word_immediate_minus) |=> s_two_cycles ##0
        q.opa == 16'($past(q.opa, 3) - {8'h00, $past(q.opb, 3)}))
        else $error("word subtract wrong or not two cycles");
    a_and_keeps_c: assert property (s_go(bitwise_conj_regs) |=> ##1
        q.opa[7:0] == ($past(q.opa[7:0], 2) & $past(q.opb, 2)) && !q.flags[`EALU_FLG_V] &&
        q.flags[`EALU_FLG_C] == $past(q.flags[`EALU_FLG_C], 2))
        else $error("AND result or flags wrong");
    a_or_result: assert property (s_go(bitwise_disj_regs) |=> ##1
        q.opa[7:0] == ($past(q.opa[7:0], 2) | $past(q.opb, 2)))
        else $error("OR result wrong");
    a_set_mask_bits: assert property (s_go(bit_set_mask) |=> ##1
        (q.opa[7:0] & $past(q.opb, 2)) == $past(q.opb, 2))
        else $error("set mask left a bit clear");
    a_clear_mask_bits: assert property (s_go(bit_clear_mask) |=> ##1
        (q.opa[7:0] & $past(q.opb, 2)) == 8'h00)
        else $error("clear mask left a bit set");
    a_inc_keeps_c: assert property (s_go(plus_one) |=> ##1
        q.opa[7:0] == 8'($past(q.opa[7:0], 2) + 8'h01) &&
        q.flags[`EALU_FLG_C] == $past(q.flags[`EALU_FLG_C], 2))
        else $error("increment wrong or carry changed");
    a_fill_zero: assert property (s_go(zero_fill) |=> ##1
        q.opa[7:0] == 8'h00 && q.flags[`EALU_FLG_Z] && !q.flags[`EALU_FLG_N])
        else $error("zero fill did not clear");
    a_umul_product: assert property (s_go(unsigned_product) |=> s_two_cycles ##0
        q.prod == $past(umul_ref, 3) && q.flags[`EALU_FLG_C] == q.prod[15])
        else $error("unsigned product wrong");
    a_smul_product: assert property (s_go(signed_product) |=> s_two_cycles ##0
        q.prod == $past(smul_ref, 3))
        else $error("signed product wrong or not two cycles");
    a_invert_result: assert property (s_go(bit_invert) |=> ##1
        q.opa[7:0] == ~$past(q.opa[7:0], 2) && q.flags[`EALU_FLG_C])
        else $error("ones complement wrong");
    a_zero_flag: assert property ((s_go(difference_regs) ##0 q.opa[7:0] == q.opb) |=> ##1
        q.flags[`EALU_FLG_Z] && !q.flags[`EALU_FLG_N])
        else $error("zero flag not set on equal operands");

endmodule // ealu_core

/* test/ealu_apb_master.sv */
// APB master model standing in for the core sequencer in front of the unit
`timescale 1ns/100ps
module ealu_apb_master (
    input wire logic pclk,
    output ealu_pkg::ealu_apb_req_s apb_req,
    input wire ealu_pkg::ealu_apb_rsp_s apb_rsp
);
    import ealu_pkg::*;

    // Bus idles with strobes low from time zero
    initial apb_req = '0;

    // One transfer: setup, access held until pready, release after that edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] rd, output logic err);
        @(posedge pclk);
        apb_req.psel <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite <= wr;
        apb_req.paddr <= a;
        apb_req.pwdata <= wd;
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        // Bench timeout cuts a slave that never answers
        @(posedge pclk);
        while (apb_rsp.pready !== 1'b1) begin
            @(posedge pclk);
        end
        // Answer is taken at the very edge that completes the transfer
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        // Released lines show the inverse so stale values are never trusted
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        apb_req.pwrite <= ~wr;
        apb_req.paddr <= ~a;
        apb_req.pwdata <= ~wd;
    endtask
endmodule // ealu_apb_master

/* test/ealu_core_test.sv */
// Self-checking bench for the arithmetic unit driven over its APB port
`timescale 1ns/100ps
`include "ealu_map.svh"
module ealu_core_test;
    import ealu_pkg::*;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    ealu_apb_req_s apb_req;
    ealu_apb_rsp_s apb_rsp;
    logic alu_busy;
    int n_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    logic [31:0] rdat;
    logic err;
    logic [15:0] last_prod = 16'h0000;
    logic [15:0] va [4] = '{16'h00FF, 16'h7F80, 16'hFFFF, 16'h0002};
    logic [7:0] vb [4] = '{8'h01, 8'h80, 8'h01, 8'h01};
    logic [5:0] vf [4] = '{6'h01, 6'h00, 6'h02, 6'h3F};

    ////////////////////////////////////////////////////////////////////////
    // Clock, design and bus model
    always #5 pclk = ~pclk;

    ealu_core dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .alu_busy(alu_busy));

    ealu_apb_master m (.pclk(pclk), .apb_req(apb_req), .apb_rsp(apb_rsp));

    ////////////////////////////////////////////////////////////////////////
    // Reporting
    task automatic conclude();
        $display("mismatches %0d, comparisons %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Hang guard, far above the length of the sequence
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register access
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
        m.xfer(1'b1, a, d, rdat, err);
        check("write error", {31'h0, err}, {31'h0, ee});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        m.xfer(1'b0, a, 32'h0000_0000, rdat, err);
        check(nm, rdat, e);
        check("read error", {31'h0, err}, 32'h0000_0000);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Reference result: {opa, flags, product}
    function automatic logic [37:0] ref_op(input ealu_op_e op, input logic [15:0] a,
            input logic [7:0] b, input logic [5:0] f);
        logic [7:0] x, y, l;
        logic [8:0] r;
        logic [4:0] h;
        logic [16:0] w;
        logic [15:0] o, p;
        logic [5:0] g;
        logic cin, sb, bw;
        x = a[7:0];
        y = b;
        o = a;
        p = 16'h0000;
        g = f;
        l = x;
        sb = op inside {difference_regs, difference_const, difference_with_borrow,
            difference_const_borrow, arith_inverse};
        bw = op inside {difference_with_borrow, difference_const_borrow};
        cin = (bw || op == sum_with_carry_in) ? f[0] : 1'b0;
        if (op == arith_inverse) begin
            x = 8'h00;
            y = a[7:0];
        end
        r = sb ? {1'b0, x} - {1'b0, y} - cin : {1'b0, x} + {1'b0, y} + cin;
        h = sb ? {1'b0, x[3:0]} - {1'b0, y[3:0]} - cin : {1'b0, x[3:0]} + {1'b0, y[3:0]} + cin;
        w = (op == word_immediate_minus) ? {1'b0, a} - {9'h0, b} : {1'b0, a} + {9'h0, b};
        case (op)
            word_immediate_plus, word_immediate_minus: begin
                o = w[15:0];
                g[3] = (op == word_immediate_plus) ? (~a[15] & w[15]) : (a[15] & ~w[15]);
                g[2:0] = {w[15], w[15:0] == 16'h0000, w[16]};
                g[4] = g[2] ^ g[3];
            end
            unsigned_product, signed_product: begin
                if (op == unsigned_product) begin
                    p = x * y;
                end else begin
                    p = $signed(x) * $signed(y);
                end
                g[1:0] = {p == 16'h0000, p[15]};
            end
            default: begin
                case (op)
                    bitwise_conj_regs, bitwise_conj_const: l = x & y;
                    bitwise_disj_regs, bitwise_disj_const, bit_set_mask: l = x | y;
                    bitwise_xor_regs: l = x ^ y;
                    bit_clear_mask: l = x & (8'hFF - y);
                    plus_one: l = x + 8'h01;
                    minus_one: l = x - 8'h01;
                    zero_sign_check: l = x & x;
                    zero_fill: l = x ^ x;
                    bit_invert: l = 8'hFF - x;
                    default: l = r[7:0];
                endcase
                o[7:0] = l;
                g[2:1] = {l[7], l == 8'h00};
                g[3] = (op == plus_one) ? l == 8'h80 : (op == minus_one) ? l == 8'h7F : 1'b0;
                if (op == bit_invert) g[0] = 1'b1;
                if (l == r[7:0] && (sb || op inside {sum_two_regs, sum_with_carry_in})) begin
                    g[0] = r[8];
                    g[5] = h[4];
                    g[3] = (sb ? x[7] != y[7] : x[7] == y[7]) && r[7] != x[7];
                    if (bw) g[1] = g[1] & f[1];
                end
            end
        endcase
        return {o, g, p};
    endfunction

    // One operation: load operands, start, time the busy phase, read back
    task automatic run(input ealu_op_e op, input logic [15:0] a, input logic [7:0] b,
            input logic [5:0] f);
        int n;
        logic [37:0] e;
        logic two;
        e = ref_op(op, a, b, f);
        two = op inside {word_immediate_plus, word_immediate_minus, unsigned_product,
            signed_product};
        wr(`EALU_OFF_OPA, {16'h0, a}, 1'b0);
        wr(`EALU_OFF_OPB, {24'h0, b}, 1'b0);
        wr(`EALU_OFF_FLAGS, {26'h0, f}, 1'b0);
        wr(`EALU_OFF_CTRL, {23'h0, 1'b1, 3'h0, op}, 1'b0);
        n = 0;
        @(negedge pclk);
        while (alu_busy === 1'b1) begin
            n++;
            @(negedge pclk);
        end
        check("busy cycles", 32'(n), two ? 32'h0000_0002 : 32'h0000_0001);
        rd(`EALU_OFF_STAT, 32'h0000_0002, "status");
        rd(`EALU_OFF_CTRL, {27'h0, op}, "op readback");
        rd(`EALU_OFF_FLAGS, {26'h0, e[21:16]}, "flags");
        if (op inside {unsigned_product, signed_product}) begin
            rd(`EALU_OFF_PROD, {16'h0, e[15:0]}, "product");
            last_prod = e[15:0];
        end else begin
            rd(`EALU_OFF_OPA, {16'h0, e[37:22]}, "result");
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        // Every register reads zero after reset
        for (int i = 0; i < 6; i++) begin
            rd(8'(i * 4), 32'h0000_0000, "reset value");
        end
        // Unmapped place and an undefined op code are refused
        m.xfer(1'b0, 8'h18, 32'h0000_0000, rdat, err);
        check("unmapped read", {31'h0, err}, 32'h0000_0001);
        m.xfer(1'b1, 8'h18, 32'h0000_0055, rdat, err);
        check("unmapped write", {31'h0, err}, 32'h0000_0001);
        wr(`EALU_OFF_CTRL, 32'h0000_0117, 1'b1);
        rd(`EALU_OFF_STAT, 32'h0000_0000, "no start");
        rd(`EALU_OFF_CTRL, 32'h0000_0000, "op kept");
        // Every op code over operand sets at carry, overflow and zero edges
        for (int op = 0; op < 23; op++) begin
            for (int k = 0; k < 4; k++) begin
                run(ealu_op_e'(op), va[k], vb[k], vf[k]);
            end
        end
        // Op code written without the go bit is held but starts nothing
        wr(`EALU_OFF_CTRL, 32'h0000_0013, 1'b0);
        rd(`EALU_OFF_CTRL, 32'h0000_0013, "op without go");
        rd(`EALU_OFF_STAT, 32'h0000_0002, "no go no start");
        // Product register ignores writes
        wr(`EALU_OFF_PROD, 32'h0000_1234, 1'b0);
        rd(`EALU_OFF_PROD, {16'h0, last_prod}, "product kept");
        conclude();
    end
endmodule // ealu_core_test
